/* File: design/meter_regs_pkg.sv */
// Purpose: Shared constants for the metering configuration and status register bank
// Assumes: 250 MHz device clock, serial link clocked by the host
// Notes:   Offsets are the 6-bit addresses carried in the command byte
package meter_regs_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [5:0] ADDR_TEMPERATURE = 6'h08;
  localparam logic [5:0] ADDR_WAVEFORM = 6'h09;
  localparam logic [5:0] ADDR_OP_CONFIG = 6'h0A;
  localparam logic [5:0] ADDR_MEAS_SELECT = 6'h0B;
  localparam logic [5:0] ADDR_WAVE_CONFIG = 6'h0C;
  localparam logic [5:0] ADDR_ACT_FORMULA = 6'h0D;
  localparam logic [5:0] ADDR_APP_FORMULA = 6'h0E;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h0F;
  localparam logic [5:0] ADDR_FLAGS = 6'h10;
  localparam logic [5:0] ADDR_FLAGS_RC = 6'h11;
  localparam logic [5:0] ADDR_ZX_TIMEOUT = 6'h12;
  localparam logic [5:0] ADDR_LINE_CYC = 6'h13;
  localparam logic [5:0] ADDR_DIP_CYC = 6'h14;
  localparam logic [5:0] ADDR_DIP_THR = 6'h15;
  localparam logic [5:0] ADDR_VOLTAGE_PEAK_THRESHOLD_THR = 6'h16;
  localparam logic [5:0] ADDR_CURRENT_PEAK_THRESHOLD_THR = 6'h17;
  localparam logic [5:0] ADDR_GAIN = 6'h18;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_OP_CONFIG = 8'h04;
  localparam logic [7:0] RST_MEAS_SELECT = 8'h70;
  localparam logic [7:0] RST_WAVE_CONFIG = 8'h00;
  localparam logic [7:0] RST_ACT_FORMULA = 8'h3F;
  localparam logic [7:0] RST_APP_FORMULA = 8'h3F;
  localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
  localparam logic [15:0] RST_ZX_TIMEOUT = 16'hFFFF;
  localparam logic [15:0] RST_LINE_CYC = 16'hFFFF;
  localparam logic [7:0] RST_DIP_CYC = 8'hFF;
  localparam logic [7:0] RST_DIP_THR = 8'h00;
  localparam logic [7:0] RST_VOLTAGE_PEAK_THRESHOLD_THR = 8'hFF;
  localparam logic [7:0] RST_CURRENT_PEAK_THRESHOLD_THR = 8'hFF;
  localparam logic [7:0] RST_GAIN = 8'h00;

  // ==========================================================================
  // Command byte and field layout
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_BITS = 8;
  localparam int WAVE_SRC_LSB = 0;
  localparam int WAVE_SRC_W = 3;
  localparam int PEAK_PHASE_LSB = 2;
  localparam int WAVE_SOURCES = 6;

  // Flag positions in the status registers
  localparam int FLAG_ZX_TIMEOUT = 0;
  localparam int FLAG_DIP = 3;
  localparam int FLAG_LINE_DONE = 6;
  localparam int FLAG_VOLTAGE_PEAK_THRESHOLD = 7;
  localparam int FLAG_CURRENT_PEAK_THRESHOLD = 8;

  // ==========================================================================
  // Timing
  localparam real CLK_HZ = 250.0e6;
  localparam real ZX_TIMEOUT_MAX_S = 2.3;
  localparam int ZX_TICK_CYCLES_DEF = int'($floor(ZX_TIMEOUT_MAX_S * CLK_HZ / 65535.0));

  function automatic logic [4:0] reg_width(input logic [5:0] addr);
    case (addr)
      ADDR_WAVEFORM: reg_width = 5'd24;
      ADDR_IRQ_MASK, ADDR_FLAGS, ADDR_FLAGS_RC, ADDR_ZX_TIMEOUT, ADDR_LINE_CYC:
        reg_width = 5'd16;
      default: reg_width = 5'd8;
    endcase
  endfunction

endpackage

/* File: design/meter_config_status_regs.sv */
// Purpose: Configuration and status register bank reached over the serial link
// Assumes: Measurement inputs are on ref_clk_i; din_i is timed by sclk_i
// Notes:   Serial state is cleared by cs_n_i high between transfers
//
// Behaviour
// - Temperature register shows latest conversion result
// - Waveform register shows sample of selected input
// - General configuration register resets to four
// - Measurement select chooses period and peak channel
// - Waveform config picks channel and sample rate
// - Active formula register, reset 3Fh
// - Apparent formula register, reset 3Fh
// - Interrupt pin low only for enabled flags
// - Status register reads without clearing flags
// - Second status view clears flags when read
// - Flag phase when zero crossing times out
// - Line accumulation spans programmed half cycles
// - Dip declared after programmed consecutive low halves
// - Shared dip threshold compared per phase
// - Voltage peak flag when above threshold
// - Current peak flag when above threshold
// - Gain register drives amplifier and summation setup
// - Transfer after command follows direction bit
`timescale 1ns/1ps

module meter_config_status_regs #(
  parameter int unsigned ZX_TICK_CYCLES = meter_regs_pkg::ZX_TICK_CYCLES_DEF
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  input wire logic temp_valid_i,
  input wire logic [7:0] temp_i,
  input wire logic wave_valid_i,
  input wire logic [meter_regs_pkg::WAVE_SOURCES*24-1:0] wave_samples_i,
  input wire logic [2:0] zero_cross_i,
  input wire logic [23:0] half_cycle_peak_i,
  input wire logic peak_valid_i,
  input wire logic [23:0] volt_mag_i,
  input wire logic [23:0] curr_mag_i,
  input wire logic [15:0] ext_event_i,
  output logic line_cycle_done_o,
  output logic [7:0] operation_config_o,
  output logic [7:0] measurement_select_o,
  output logic [7:0] waveform_capture_config_o,
  output logic [7:0] active_energy_formula_o,
  output logic [7:0] apparent_energy_formula_o,
  output logic [7:0] amplifier_gain_config_o
);
  import meter_regs_pkg::*;

  // A zero tick length would make the watchdog prescaler compare wrap and tick only once every 2^32 device cycles
  if (ZX_TICK_CYCLES < 1) begin : g_tick_check
    $error("ZX_TICK_CYCLES must be at least one");
  end

  // ==========================================================================
  // Link side, clocked by the host clock
  typedef struct packed {
    logic [5:0] bit_cnt;
    logic [7:0] cmd;
    logic [23:0] shift;
    logic [23:0] wr_data;
    logic wr_pend;
    logic rd_pend;
    logic dout;
    logic dout_oe;
  } link_s;

  link_s link_reg;
  link_s link_next;

  // ==========================================================================
  // Register side, clocked by the device clock
  typedef struct packed {
    logic [2:0] wr_sync;
    logic [2:0] rd_sync;
    logic [7:0] temperature;
    logic [23:0] waveform;
    logic [7:0] op_config;
    logic [7:0] meas_select;
    logic [7:0] wave_config;
    logic [7:0] act_formula;
    logic [7:0] app_formula;
    logic [15:0] irq_mask;
    logic [15:0] flags;
    logic [15:0] zx_timeout;
    logic [15:0] line_cyc;
    logic [7:0] dip_cyc;
    logic [7:0] dip_thr;
    logic [7:0] voltage_peak_threshold_thr;
    logic [7:0] current_peak_threshold_thr;
    logic [7:0] gain;
    logic [23:0] rd_word;
    logic [31:0] tick_cnt;
    logic [47:0] zx_cnt;
    logic [23:0] dip_cnt;
    logic [15:0] line_cnt;
    logic line_done;
    logic irq_oe;
  } regs_s;

  regs_s regs_reg;
  regs_s regs_next;

  // ==========================================================================
  // Serial shifter; data in on rising edges, data out changes on rising edges
  always_comb begin
    link_next = link_reg;
    link_next.shift = {link_reg.shift[22:0], din_i};
    if (link_reg.bit_cnt != 6'h3F) begin
      link_next.bit_cnt = link_reg.bit_cnt + 6'h01;
    end
    if (link_reg.bit_cnt == 6'(CMD_BITS - 1)) begin
      link_next.cmd = link_next.shift[7:0];
      link_next.rd_pend = ~link_next.shift[CMD_DIR_BIT];
    end
    if (link_reg.bit_cnt >= 6'(CMD_BITS)) begin
      if (link_reg.cmd[CMD_DIR_BIT]) begin
        if (link_reg.bit_cnt == 6'(CMD_BITS - 1) + 6'(reg_width(link_reg.cmd[5:0]))) begin
          link_next.wr_data = link_next.shift;
          link_next.wr_pend = 1'b1;
        end
      end else if (link_reg.bit_cnt < 6'(CMD_BITS) + 6'(reg_width(link_reg.cmd[5:0]))) begin
        // The read word was captured tens of device cycles ago and holds still
        link_next.dout = regs_reg.rd_word[5'(6'(CMD_BITS - 1)
          + 6'(reg_width(link_reg.cmd[5:0])) - link_reg.bit_cnt)];
        link_next.dout_oe = 1'b1;
      end else begin
        link_next.dout_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // ==========================================================================
  // Register bank and event logic
  logic [23:0] read_value;
  logic [15:0] flag_set;

  always_comb begin
    case (link_reg.cmd[5:0])
      ADDR_TEMPERATURE: read_value = {16'h0000, regs_reg.temperature};
      ADDR_WAVEFORM: read_value = regs_reg.waveform;
      ADDR_OP_CONFIG: read_value = {16'h0000, regs_reg.op_config};
      ADDR_MEAS_SELECT: read_value = {16'h0000, regs_reg.meas_select};
      ADDR_WAVE_CONFIG: read_value = {16'h0000, regs_reg.wave_config};
      ADDR_ACT_FORMULA: read_value = {16'h0000, regs_reg.act_formula};
      ADDR_APP_FORMULA: read_value = {16'h0000, regs_reg.app_formula};
      ADDR_IRQ_MASK: read_value = {8'h00, regs_reg.irq_mask};
      ADDR_FLAGS, ADDR_FLAGS_RC: read_value = {8'h00, regs_reg.flags};
      ADDR_ZX_TIMEOUT: read_value = {8'h00, regs_reg.zx_timeout};
      ADDR_LINE_CYC: read_value = {8'h00, regs_reg.line_cyc};
      ADDR_DIP_CYC: read_value = {16'h0000, regs_reg.dip_cyc};
      ADDR_DIP_THR: read_value = {16'h0000, regs_reg.dip_thr};
      ADDR_VOLTAGE_PEAK_THRESHOLD_THR: read_value = {16'h0000, regs_reg.voltage_peak_threshold_thr};
      ADDR_CURRENT_PEAK_THRESHOLD_THR: read_value = {16'h0000, regs_reg.current_peak_threshold_thr};
      ADDR_GAIN: read_value = {16'h0000, regs_reg.gain};
      default: read_value = 24'h000000;
    endcase
  end

  always_comb begin
    logic wr_evt;
    logic rd_evt;
    logic tick;
    logic [1:0] pk_phase;
    logic [7:0] dip_inc;
    logic [15:0] line_inc;
    wr_evt = 1'b0;
    rd_evt = 1'b0;
    tick = 1'b0;
    pk_phase = 2'b00;
    dip_inc = 8'h00;
    line_inc = 16'h0000;
    flag_set = ext_event_i;
    regs_next = regs_reg;
    regs_next.wr_sync = {regs_reg.wr_sync[1:0], link_reg.wr_pend};
    regs_next.rd_sync = {regs_reg.rd_sync[1:0], link_reg.rd_pend};
    wr_evt = regs_reg.wr_sync[1] & ~regs_reg.wr_sync[2];
    rd_evt = regs_reg.rd_sync[1] & ~regs_reg.rd_sync[2];
    regs_next.line_done = 1'b0;

    if (temp_valid_i) begin
      regs_next.temperature = temp_i;
    end
    if (wave_valid_i && regs_reg.wave_config[WAVE_SRC_LSB +: WAVE_SRC_W] < 3'(WAVE_SOURCES)) begin
      regs_next.waveform = wave_samples_i[24 * regs_reg.wave_config[WAVE_SRC_LSB +: WAVE_SRC_W]
        +: 24];
    end

    // Zero-crossing watchdog: each phase reloads on its crossing, counts ticks down
    if (regs_reg.tick_cnt >= ZX_TICK_CYCLES - 1) begin
      regs_next.tick_cnt = 32'h00000000;
      tick = 1'b1;
    end else begin
      regs_next.tick_cnt = regs_reg.tick_cnt + 32'h00000001;
    end
    for (int p = 0; p < 3; p++) begin
      if (zero_cross_i[p]) begin
        regs_next.zx_cnt[16*p +: 16] = regs_reg.zx_timeout;
        // Dip: count consecutive low half cycles against the shared threshold
        if (half_cycle_peak_i[8*p +: 8] < regs_reg.dip_thr) begin
          dip_inc = regs_reg.dip_cnt[8*p +: 8] + 8'h01;
          if (regs_reg.dip_cnt[8*p +: 8] != 8'hFF) begin
            regs_next.dip_cnt[8*p +: 8] = dip_inc;
          end
          if (dip_inc == regs_reg.dip_cyc) begin
            flag_set[FLAG_DIP + p] = 1'b1;
          end
        end else begin
          regs_next.dip_cnt[8*p +: 8] = 8'h00;
        end
      end else if (tick && regs_reg.zx_cnt[16*p +: 16] != 16'h0000) begin
        regs_next.zx_cnt[16*p +: 16] = regs_reg.zx_cnt[16*p +: 16] - 16'h0001;
        if (regs_reg.zx_cnt[16*p +: 16] == 16'h0001) begin
          flag_set[FLAG_ZX_TIMEOUT + p] = 1'b1;
        end
      end
    end

    // Line accumulation window counted in phase A half cycles
    if (zero_cross_i[0]) begin
      line_inc = regs_reg.line_cnt + 16'h0001;
      if (line_inc >= regs_reg.line_cyc) begin
        regs_next.line_cnt = 16'h0000;
        regs_next.line_done = 1'b1;
        flag_set[FLAG_LINE_DONE] = 1'b1;
      end else begin
        regs_next.line_cnt = line_inc;
      end
    end

    pk_phase = regs_reg.meas_select[PEAK_PHASE_LSB +: 2];
    if (peak_valid_i && pk_phase != 2'b11) begin
      if (volt_mag_i[8*pk_phase +: 8] > regs_reg.voltage_peak_threshold_thr) begin
        flag_set[FLAG_VOLTAGE_PEAK_THRESHOLD] = 1'b1;
      end
      if (curr_mag_i[8*pk_phase +: 8] > regs_reg.current_peak_threshold_thr) begin
        flag_set[FLAG_CURRENT_PEAK_THRESHOLD] = 1'b1;
      end
    end

    if (rd_evt) begin
      regs_next.rd_word = read_value;
      if (link_reg.cmd[5:0] == ADDR_FLAGS_RC) begin
        regs_next.flags = 16'h0000;
      end
    end
    // New events win over a clear in the same cycle
    regs_next.flags = regs_next.flags | flag_set;

    if (wr_evt) begin
      case (link_reg.cmd[5:0])
        ADDR_OP_CONFIG: regs_next.op_config = link_reg.wr_data[7:0];
        ADDR_MEAS_SELECT: regs_next.meas_select = link_reg.wr_data[7:0];
        ADDR_WAVE_CONFIG: regs_next.wave_config = link_reg.wr_data[7:0];
        ADDR_ACT_FORMULA: regs_next.act_formula = link_reg.wr_data[7:0];
        ADDR_APP_FORMULA: regs_next.app_formula = link_reg.wr_data[7:0];
        ADDR_IRQ_MASK: regs_next.irq_mask = link_reg.wr_data[15:0];
        ADDR_ZX_TIMEOUT: regs_next.zx_timeout = link_reg.wr_data[15:0];
        ADDR_LINE_CYC: regs_next.line_cyc = link_reg.wr_data[15:0];
        ADDR_DIP_CYC: regs_next.dip_cyc = link_reg.wr_data[7:0];
        ADDR_DIP_THR: regs_next.dip_thr = link_reg.wr_data[7:0];
        ADDR_VOLTAGE_PEAK_THRESHOLD_THR: regs_next.voltage_peak_threshold_thr = link_reg.wr_data[7:0];
        ADDR_CURRENT_PEAK_THRESHOLD_THR: regs_next.current_peak_threshold_thr = link_reg.wr_data[7:0];
        ADDR_GAIN: regs_next.gain = link_reg.wr_data[7:0];
        default: ; // Read-only and unmapped addresses keep their value
      endcase
    end

    regs_next.irq_oe = |(regs_next.flags & regs_next.irq_mask);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      regs_reg <= '0;
      regs_reg.op_config <= RST_OP_CONFIG;
      regs_reg.meas_select <= RST_MEAS_SELECT;
      regs_reg.wave_config <= RST_WAVE_CONFIG;
      regs_reg.act_formula <= RST_ACT_FORMULA;
      regs_reg.app_formula <= RST_APP_FORMULA;
      regs_reg.irq_mask <= RST_IRQ_MASK;
      regs_reg.zx_timeout <= RST_ZX_TIMEOUT;
      regs_reg.zx_cnt <= {RST_ZX_TIMEOUT, RST_ZX_TIMEOUT, RST_ZX_TIMEOUT};
      regs_reg.line_cyc <= RST_LINE_CYC;
      regs_reg.dip_cyc <= RST_DIP_CYC;
      regs_reg.dip_thr <= RST_DIP_THR;
      regs_reg.voltage_peak_threshold_thr <= RST_VOLTAGE_PEAK_THRESHOLD_THR;
      regs_reg.current_peak_threshold_thr <= RST_CURRENT_PEAK_THRESHOLD_THR;
      regs_reg.gain <= RST_GAIN;
    end else begin
      regs_reg <= regs_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign dout_o = link_reg.dout;
  assign dout_oe_o = link_reg.dout_oe;
  assign irq_o = 1'b0;
  assign irq_oe_o = regs_reg.irq_oe;
  assign line_cycle_done_o = regs_reg.line_done;
  assign operation_config_o = regs_reg.op_config;
  assign measurement_select_o = regs_reg.meas_select;
  assign waveform_capture_config_o = regs_reg.wave_config;
  assign active_energy_formula_o = regs_reg.act_formula;
  assign apparent_energy_formula_o = regs_reg.app_formula;
  assign amplifier_gain_config_o = regs_reg.gain;

endmodule // meter_config_status_regs

/* File: verification/meter_regs_monitor.sv */
// Purpose: Port-level checks of the metering register bank
// Assumes: Link state is cleared while cs_n_i is high
// Notes: Frame position is rebuilt from sclk_i edges
`timescale 1ns/1ps
module meter_regs_monitor #(
  parameter int unsigned ZX_TICK_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic dout_oe_o,
  input wire logic irq_o,
  input wire logic irq_oe_o,
  input wire logic [2:0] zero_cross_i,
  input wire logic line_cycle_done_o,
  input wire logic [7:0] operation_config_o,
  input wire logic [7:0] measurement_select_o,
  input wire logic [7:0] waveform_capture_config_o,
  input wire logic [7:0] active_energy_formula_o,
  input wire logic [7:0] apparent_energy_formula_o,
  input wire logic [7:0] amplifier_gain_config_o
);
  logic [5:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [5:0] data_width;
  // ====================
  // Frame tracking, count saturates so long frames cannot wrap
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_reg <= 6'h00;
      cmd_reg <= 8'h00;
    end else begin
      if (bit_cnt_reg != 6'h3F) bit_cnt_reg <= bit_cnt_reg + 6'h01;
      if (bit_cnt_reg < 6'h08) cmd_reg <= {cmd_reg[6:0], din_i};
    end
  end
  always_comb begin
    case (cmd_reg[5:0])
      6'h09: data_width = 6'h18;
      6'h0F, 6'h10, 6'h11, 6'h12, 6'h13: data_width = 6'h10;
      default: data_width = 6'h08;
    endcase
  end
  // ====================
  // Assertions
  sequence s_release;
    $fell(rst_i);
  endsequence
  sequence s_done_once;
    line_cycle_done_o ##1 !line_cycle_done_o;
  endsequence
  a_cfg_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_release |->
    {operation_config_o, measurement_select_o, waveform_capture_config_o} == 24'h047000)
    else $error("mode registers wrong after reset");
  a_formula_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_release |->
    {active_energy_formula_o, apparent_energy_formula_o, amplifier_gain_config_o} == 24'h3F3F00)
    else $error("formula or gain wrong after reset");
  a_flags_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_release |-> !irq_oe_o && !line_cycle_done_o) else $error("interrupt active after reset");
  a_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i) irq_o == 1'b0)
    else $error("interrupt pin drives high");
  a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    line_cycle_done_o |-> s_done_once) else $error("line done longer than one cycle");
  a_done_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    line_cycle_done_o |-> $past(zero_cross_i[0]) || $past(zero_cross_i[0], 2)
    || $past(zero_cross_i[0], 3)) else $error("line done without phase A crossing");
  a_oe_idle: assert property (@(posedge ref_clk_i) cs_n_i |-> !dout_oe_o)
    else $error("data out driven while deselected");
  a_read_window: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    bit_cnt_reg >= 6'h08 && !cmd_reg[7] && cmd_reg[5:0] >= 6'h08 && cmd_reg[5:0] <= 6'h18
    |-> dout_oe_o == (bit_cnt_reg >= 6'h09 && bit_cnt_reg <= 6'h08 + data_width))
    else $error("read data window wrong");
  a_write_quiet: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    bit_cnt_reg <= 6'h08 || cmd_reg[7] |-> !dout_oe_o) else $error("data out driven in write");
endmodule // meter_regs_monitor

bind meter_config_status_regs meter_regs_monitor #(.ZX_TICK_CYCLES(ZX_TICK_CYCLES)) i_mon (
  .ref_clk_i, .rst_i, .sclk_i, .cs_n_i, .din_i, .dout_oe_o, .irq_o, .irq_oe_o, .zero_cross_i,
  .line_cycle_done_o, .operation_config_o, .measurement_select_o, .waveform_capture_config_o,
  .active_energy_formula_o, .apparent_energy_formula_o, .amplifier_gain_config_o);

/* File: verification/spi_host_model.sv */
// Purpose: Host side of the serial register link
// Assumes: Link clock of 160 ns that stands low outside frames
// Notes: Released data in shows the inverse of its last bit
`timescale 1ns/1ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic [23:0] rd_data_o,
  output logic rd_done_o
);
  initial begin
    {sclk_o, cs_n_o, din_o, rd_done_o} = 4'b0000;
    rd_data_o = 24'h000000;
    // Select starts low so its later rise is a real edge that clears the link
    #20 cs_n_o = 1'b1;
  end
  // ====================
  // One command byte, then one data word in the same frame
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdata, input int width);
    logic [31:0] word;
    logic [23:0] rdata;
    word = {cmd[7], 1'b0, cmd[5:0], wdata << (24 - width)};
    rdata = 24'h000000;
    // Odd offset keeps the link out of step with the device clock
    #13.7 cs_n_o = 1'b0;
    for (int i = 0; i < 8 + width; i++) begin
      din_o = word[31 - i];
      #80 sclk_o = 1'b1;
      #80 sclk_o = 1'b0;
      if (i >= 8) rdata = {rdata[22:0], dout_oe_i ? dout_i : 1'bx};
    end
    if (!cmd[7]) begin
      rd_data_o = rdata;
      rd_done_o = 1'b1;
    end
    din_o = ~din_o;
    #40 cs_n_o = 1'b1;
    #40 rd_done_o = 1'b0;
  endtask
endmodule // spi_host_model

/* File: verification/tb_meter_config_status_regs.sv */
// Purpose: Self-checking bench of the metering register bank
// Assumes: Timeout tick shortened to 4 device clocks
// Notes: Read words are queued as expected and compared on arrival
`timescale 1ns/1ps
module tb_meter_config_status_regs;
  import meter_regs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, irq_o, irq_oe_o, line_cycle_done_o, rd_done;
  logic temp_valid_i = 1'b0, wave_valid_i = 1'b0, peak_valid_i = 1'b0;
  logic [7:0] temp_i = 8'h00;
  logic [WAVE_SOURCES*24-1:0] wave_samples_i = '0;
  logic [2:0] zero_cross_i = 3'h0;
  logic [23:0] half_cycle_peak_i = 24'hFFFFFF, volt_mag_i = 24'h0, curr_mag_i = 24'h0, rd_data;
  logic [15:0] ext_event_i = 16'h0000;
  logic [7:0] operation_config_o, measurement_select_o, waveform_capture_config_o;
  logic [7:0] active_energy_formula_o, apparent_energy_formula_o, amplifier_gain_config_o;
  wire [23:0] cfg_a = {operation_config_o, measurement_select_o, waveform_capture_config_o};
  wire [23:0] cfg_b = {active_energy_formula_o, apparent_energy_formula_o, amplifier_gain_config_o};
  logic [15:0] rv [17] = '{16'h0, 16'h0, 16'h04, 16'h70, 16'h00, 16'h3F, 16'h3F, 16'h0, 16'h0,
    16'h0, 16'hFFFF, 16'hFFFF, 16'hFF, 16'h00, 16'hFF, 16'hFF, 16'h00};
  logic [5:0] ro [5] = '{6'h08, 6'h09, 6'h10, 6'h11, 6'h3F};
  logic [23:0] exp_q [$];
  int err_total = 0;
  int checked = 0;
  int done_cnt = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  meter_config_status_regs #(.ZX_TICK_CYCLES(4)) i_dut (.ref_clk_i, .rst_i, .sclk_i, .cs_n_i,
    .din_i, .dout_o, .dout_oe_o, .irq_o, .irq_oe_o, .temp_valid_i, .temp_i, .wave_valid_i,
    .wave_samples_i, .zero_cross_i, .half_cycle_peak_i, .peak_valid_i, .volt_mag_i, .curr_mag_i,
    .ext_event_i, .line_cycle_done_o, .operation_config_o, .measurement_select_o,
    .waveform_capture_config_o, .active_energy_formula_o, .apparent_energy_formula_o,
    .amplifier_gain_config_o);
  spi_host_model i_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o),
    .dout_oe_i(dout_oe_o), .rd_data_o(rd_data), .rd_done_o(rd_done));
  // ====================
  // Helpers
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] expv);
    checked++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  function automatic int wid(input logic [5:0] a);
    return a == 6'h09 ? 24 : (a == 6'h0F || (a >= 6'h10 && a <= 6'h13)) ? 16 : 8;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    i_host.xfer({2'b10, a}, d, wid(a));
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    i_host.xfer({2'b00, a}, 24'h0, wid(a));
    @(negedge ref_clk_i);
  endtask
  task automatic pulse(input logic [2:0] v, input logic [2:0] zc, input logic [15:0] ev);
    @(negedge ref_clk_i);
    {temp_valid_i, wave_valid_i, peak_valid_i, zero_cross_i, ext_event_i} = {v, zc, ev};
    @(negedge ref_clk_i);
    {temp_valid_i, wave_valid_i, peak_valid_i, zero_cross_i, ext_event_i} = '0;
    repeat (4) @(negedge ref_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge rd_done) check("read word", rd_data, exp_q.pop_front());
  always @(posedge ref_clk_i) if (line_cycle_done_o === 1'b1) done_cnt++;
  initial begin
    #400000;
    err_total++;
    $display("[FAIL] watchdog expected end seen hang");
    tally_and_finish();
  end
  // ====================
  // Tests
  initial begin
    logic [23:0] d;
    logic [23:0] wv [17];
    void'($urandom(72));
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 17; i++) begin
      rd(6'(8 + i), 24'(rv[i]));
    end
    check("cfg_a", cfg_a, 24'h047000);
    check("cfg_b", cfg_b, 24'h3F3F00);
    $display("reset test done");
    for (int i = 2; i < 17; i++) begin
      if (i == 8 || i == 9) continue;
      d = 24'($urandom) & ((24'h1 << wid(6'(8 + i))) - 24'h1);
      // Long timeout only, so no phase times out before the timeout test
      if (i == 10) d[15] = 1'b1;
      wv[i] = d;
      wr(6'(8 + i), d);
      rd(6'(8 + i), d);
    end
    check("cfg_a", cfg_a, {wv[2][7:0], wv[3][7:0], wv[4][7:0]});
    check("cfg_b", cfg_b, {wv[5][7:0], wv[6][7:0], wv[16][7:0]});
    foreach (ro[k]) wr(ro[k], 24'($urandom));
    foreach (ro[k]) rd(ro[k], 24'h0);
    $display("access test done");
    temp_i = 8'($urandom);
    pulse(3'b100, 3'h0, 16'h0);
    rd(6'h08, {16'h0, temp_i});
    for (int s = 0; s < 6; s++) begin
      wr(6'h0C, 24'(s));
      for (int j = 0; j < 6; j++) wave_samples_i[24 * j +: 24] = 24'($urandom);
      pulse(3'b010, 3'h0, 16'h0);
      rd(6'h09, wave_samples_i[24 * s +: 24]);
    end
    d = wave_samples_i[120 +: 24];
    wr(6'h0C, 24'h6);
    wave_samples_i = {6{24'($urandom)}};
    pulse(3'b010, 3'h0, 16'h0);
    rd(6'h09, d);
    $display("sample test done");
    wr(6'h0F, 24'h0);
    pulse(3'b000, 3'h0, 16'h1000);
    check("irq masked", 24'(irq_oe_o), 24'h0);
    rd(6'h10, 24'h001000);
    rd(6'h10, 24'h001000);
    wr(6'h0F, 24'h001000);
    check("irq enabled", 24'(irq_oe_o), 24'h1);
    rd(6'h11, 24'h001000);
    rd(6'h10, 24'h0);
    check("irq cleared", 24'(irq_oe_o), 24'h0);
    $display("flag test done");
    wr(6'h0B, 24'h0);
    wr(6'h16, 24'h40);
    wr(6'h17, 24'h40);
    {volt_mag_i, curr_mag_i} = {24'h000041, 24'h7F7F40};
    pulse(3'b001, 3'h0, 16'h0);
    rd(6'h11, 24'h000080);
    wr(6'h0B, 24'h08);
    {volt_mag_i, curr_mag_i} = {24'h407F7F, 24'h410000};
    pulse(3'b001, 3'h0, 16'h0);
    rd(6'h11, 24'h000100);
    wr(6'h0B, 24'h0C);
    {volt_mag_i, curr_mag_i} = {24'hFFFFFF, 24'hFFFFFF};
    pulse(3'b001, 3'h0, 16'h0);
    rd(6'h11, 24'h0);
    $display("peak test done");
    wr(6'h13, 24'h3);
    repeat (2) pulse(3'b000, 3'b001, 16'h0);
    check("early done", 24'(done_cnt), 24'h0);
    pulse(3'b000, 3'b001, 16'h0);
    check("line done", 24'(done_cnt), 24'h1);
    rd(6'h11, 24'h000040);
    $display("line test done");
    wr(6'h15, 24'h20);
    wr(6'h14, 24'h2);
    half_cycle_peak_i = 24'hFF10FF;
    pulse(3'b000, 3'b010, 16'h0);
    rd(6'h11, 24'h0);
    pulse(3'b000, 3'b010, 16'h0);
    rd(6'h11, 24'h000010);
    $display("dip test done");
    wr(6'h12, 24'h2);
    pulse(3'b000, 3'b111, 16'h0);
    rd(6'h11, 24'h000007);
    $display("timeout test done");
    tally_and_finish();
  end
endmodule // tb_meter_config_status_regs
